// [rtl/pgp_pkg.sv]
// Package with register map, fields and encodings of the planar path
package pgp_pkg;
   localparam logic [15:0] INDEX_PORT_ADDR = 16'h03ce;
   localparam logic [15:0] DATA_PORT_ADDR  = 16'h03cf;
   localparam logic [3:0] REG_FILL_COLOR    = 4'h0;
   localparam logic [3:0] REG_FILL_ENABLE   = 4'h1;
   localparam logic [3:0] REG_COMPARE_COLOR = 4'h2;
   localparam logic [3:0] REG_ROTATE_OP     = 4'h3;
   localparam logic [3:0] REG_READ_PLANE    = 4'h4;
   localparam logic [3:0] REG_PATH_MODE     = 4'h5;
   localparam logic [3:0] REG_MEM_MAP       = 4'h6;
   localparam logic [3:0] REG_COMPARE_IGN   = 4'h7;
   localparam logic [3:0] REG_BIT_MASK      = 4'h8;
   localparam logic [7:0] RESET_VALUE       = 8'h00;
   localparam logic [7:0] INDEX_MASK        = 8'h0f;
   localparam logic [7:0] FILL_COLOR_MASK   = 8'h0f;
   localparam logic [7:0] FILL_ENABLE_MASK  = 8'h0f;
   localparam logic [7:0] COMPARE_MASK      = 8'h0f;
   localparam logic [7:0] ROTATE_OP_MASK    = 8'h1f;
   localparam logic [7:0] READ_PLANE_MASK   = 8'h03;
   localparam logic [7:0] PATH_MODE_MASK    = 8'h7b;
   localparam logic [7:0] MEM_MAP_MASK      = 8'h0f;
   localparam logic [7:0] IGNORE_MASK       = 8'h0f;
   localparam logic [7:0] BIT_MASK_MASK     = 8'hff;
   localparam int ROT_LSB = 0;
   localparam int ROT_MSB = 2;
   localparam int OP_LSB  = 3;
   localparam int OP_MSB  = 4;
   localparam int WMODE_LSB = 0;
   localparam int WMODE_MSB = 1;
   localparam int CMP_EN_BIT = 3;
   localparam int OE_ADDR_BIT = 4;
   localparam int OE_SHIFT_BIT = 5;
   localparam int C256_BIT = 6;
   localparam int GFX_BIT = 0;
   localparam int CHAIN_BIT = 1;
   localparam int WIN_LSB = 2;
   localparam int WIN_MSB = 3;
   typedef enum logic [1:0] {
      PGP_OP_REPLACE = 2'h0,
      PGP_OP_AND     = 2'h1,
      PGP_OP_OR      = 2'h2,
      PGP_OP_XOR     = 2'h3
   } pgp_op_t;
endpackage

// [rtl/pgp_cfg_if.sv]
// Interface carrying decoded controls from register file to the datapath
`timescale 1ns/1ps
interface pgp_cfg_if;
   logic [3:0] fill_color;
   logic [3:0] fill_enable;
   logic [2:0] rotate;
   logic [1:0] op;
   logic [7:0] bit_mask;
   modport regs (output fill_color, fill_enable, rotate, op, bit_mask);
   modport path (input  fill_color, fill_enable, rotate, op, bit_mask);
endinterface

// [rtl/pgp_write_lane.sv]
// Write datapath: rotate, fill, logic function and bit mask for four planes
`timescale 1ns/1ps
module pgp_write_lane (
   pgp_cfg_if.path          cfg,
   input  wire logic [7:0]  host_data_in,
   input  wire logic [31:0] latch_in,
   output logic [31:0]      plane_data_out
);
   logic [7:0] rotated;

   always_comb begin
      rotated = (host_data_in >> cfg.rotate) |
                8'((16'(host_data_in) << (4'h8 - {1'b0, cfg.rotate})));
   end

   genvar p;
   for (p = 0; p < 4; p++) begin : g_plane
      logic [7:0] src;
      logic [7:0] lat;
      logic [7:0] res;
      always_comb begin
         lat = latch_in[p*8 +: 8];
         src = cfg.fill_enable[p] ? {8{cfg.fill_color[p]}} : rotated;
         case (cfg.op)
            pgp_pkg::PGP_OP_AND: res = src & lat;
            pgp_pkg::PGP_OP_OR:  res = src | lat;
            pgp_pkg::PGP_OP_XOR: res = src ^ lat;
            default:             res = src;
         endcase
         plane_data_out[p*8 +: 8] = (res & cfg.bit_mask) |
                                    (lat & ~cfg.bit_mask);
      end
   end
endmodule

// [rtl/pgp_top.sv]
// Planar graphics write/read path with index/data register ports
`timescale 1ns/1ps
module pgp_top (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        io_wr_in,
   input  wire logic        io_rd_in,
   input  wire logic [15:0] io_addr_in,
   input  wire logic [7:0]  io_wdata_in,
   output logic [7:0]       io_rdata_out,
   output logic             io_rvalid_out,
   input  wire logic        mem_wr_in,
   input  wire logic        mem_rd_in,
   input  wire logic [7:0]  mem_wdata_in,
   input  wire logic [31:0] mem_plane_rdata_in,
   output logic [7:0]       mem_rdata_out,
   output logic             mem_rvalid_out,
   output logic [31:0]      plane_wdata_out,
   output logic             plane_we_out,
   output logic [1:0]       write_mode_out,
   output logic             odd_even_addr_out,
   output logic             odd_even_shift_out,
   output logic             shift_256_out,
   output logic             gfx_addr_out,
   output logic             chain_odd_even_out,
   output logic [1:0]       mem_window_out
);
   localparam int NUM_REGS = 9;

   logic [3:0]  index_q;
   logic [7:0]  regs_q [NUM_REGS];
   logic [31:0] latch_q;
   logic [7:0]  sel_rdata;
   logic [7:0]  cmp_result;
   logic [31:0] lane_out;
   logic [7:0]  mask_tab [NUM_REGS];
   logic        idx_hit;
   logic        dat_hit;

   pgp_cfg_if cfg ();

   assign mask_tab[0] = pgp_pkg::FILL_COLOR_MASK;
   assign mask_tab[1] = pgp_pkg::FILL_ENABLE_MASK;
   assign mask_tab[2] = pgp_pkg::COMPARE_MASK;
   assign mask_tab[3] = pgp_pkg::ROTATE_OP_MASK;
   assign mask_tab[4] = pgp_pkg::READ_PLANE_MASK;
   assign mask_tab[5] = pgp_pkg::PATH_MODE_MASK;
   assign mask_tab[6] = pgp_pkg::MEM_MAP_MASK;
   assign mask_tab[7] = pgp_pkg::IGNORE_MASK;
   assign mask_tab[8] = pgp_pkg::BIT_MASK_MASK;

   assign idx_hit = (io_addr_in == pgp_pkg::INDEX_PORT_ADDR);
   assign dat_hit = (io_addr_in == pgp_pkg::DATA_PORT_ADDR);

   // Index register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         index_q <= 4'h0;
      end else if (io_wr_in && idx_hit) begin
         index_q <= io_wdata_in[3:0];
      end
   end

   // Control registers, reserved bits masked off on write
   genvar r;
   for (r = 0; r < NUM_REGS; r++) begin : g_reg
      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            regs_q[r] <= pgp_pkg::RESET_VALUE;
         end else if (io_wr_in && dat_hit && index_q == 4'(r)) begin
            regs_q[r] <= io_wdata_in & mask_tab[r];
         end
      end
   end

   // Control fields
   assign cfg.fill_color  = regs_q[pgp_pkg::REG_FILL_COLOR][3:0];
   assign cfg.fill_enable = regs_q[pgp_pkg::REG_FILL_ENABLE][3:0];
   assign cfg.rotate = regs_q[pgp_pkg::REG_ROTATE_OP]
      [pgp_pkg::ROT_MSB:pgp_pkg::ROT_LSB];
   assign cfg.op =
      regs_q[pgp_pkg::REG_ROTATE_OP][pgp_pkg::OP_MSB:pgp_pkg::OP_LSB];
   assign cfg.bit_mask = regs_q[pgp_pkg::REG_BIT_MASK];

   pgp_write_lane u_lane (
      .cfg            (cfg),
      .host_data_in   (mem_wdata_in),
      .latch_in       (latch_q),
      .plane_data_out (lane_out)
   );

   // Register read mux
   always_comb begin
      if (idx_hit) begin
         sel_rdata = {4'h0, index_q};
      end else if (dat_hit && index_q < 4'(NUM_REGS)) begin
         sel_rdata = regs_q[index_q];
      end else begin
         sel_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         io_rdata_out  <= 8'h00;
         io_rvalid_out <= 1'b0;
      end else begin
         io_rvalid_out <= io_rd_in;
         io_rdata_out  <= io_rd_in ? sel_rdata : 8'h00;
      end
   end

   // Color compare: per bit, matches in all enabled planes
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         cmp_result[b] = 1'b1;
         for (int p = 0; p < 4; p++) begin
            if (regs_q[pgp_pkg::REG_COMPARE_IGN][p] &&
                (mem_plane_rdata_in[p*8 + b] !=
                 regs_q[pgp_pkg::REG_COMPARE_COLOR][p])) begin
               cmp_result[b] = 1'b0;
            end
         end
      end
   end

   // Plane latch loads on every host memory read
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         latch_q <= 32'h0;
      end else if (mem_rd_in) begin
         latch_q <= mem_plane_rdata_in;
      end
   end

   // Host read data
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mem_rdata_out  <= 8'h00;
         mem_rvalid_out <= 1'b0;
      end else begin
         mem_rvalid_out <= mem_rd_in;
         if (!mem_rd_in) begin
            mem_rdata_out <= 8'h00;
         end else if (regs_q[pgp_pkg::REG_PATH_MODE]
                      [pgp_pkg::CMP_EN_BIT]) begin
            mem_rdata_out <= cmp_result;
         end else begin
            mem_rdata_out <= mem_plane_rdata_in[
               {regs_q[pgp_pkg::REG_READ_PLANE][1:0], 3'h0} +: 8];
         end
      end
   end

   // Plane write data
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         plane_wdata_out <= 32'h0;
         plane_we_out    <= 1'b0;
      end else begin
         plane_we_out    <= mem_wr_in;
         plane_wdata_out <= mem_wr_in ? lane_out : plane_wdata_out;
      end
   end

   // Mode outputs
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         write_mode_out     <= 2'h0;
         odd_even_addr_out  <= 1'b0;
         odd_even_shift_out <= 1'b0;
         shift_256_out      <= 1'b0;
         gfx_addr_out       <= 1'b0;
         chain_odd_even_out <= 1'b0;
         mem_window_out     <= 2'h0;
      end else begin
         write_mode_out <= regs_q[pgp_pkg::REG_PATH_MODE]
            [pgp_pkg::WMODE_MSB:pgp_pkg::WMODE_LSB];
         odd_even_addr_out <=
            regs_q[pgp_pkg::REG_PATH_MODE][pgp_pkg::OE_ADDR_BIT];
         odd_even_shift_out <=
            regs_q[pgp_pkg::REG_PATH_MODE][pgp_pkg::OE_SHIFT_BIT];
         shift_256_out <=
            regs_q[pgp_pkg::REG_PATH_MODE][pgp_pkg::C256_BIT];
         gfx_addr_out <=
            regs_q[pgp_pkg::REG_MEM_MAP][pgp_pkg::GFX_BIT];
         chain_odd_even_out <=
            regs_q[pgp_pkg::REG_MEM_MAP][pgp_pkg::CHAIN_BIT];
         mem_window_out <= regs_q[pgp_pkg::REG_MEM_MAP]
            [pgp_pkg::WIN_MSB:pgp_pkg::WIN_LSB];
      end
   end

   // Checks
   property p_idx_write;
      @(posedge clk_in) disable iff (rst_in)
      (io_wr_in && idx_hit) |=> (index_q == $past(io_wdata_in[3:0]));
   endproperty
   a_idx_write: assert property (p_idx_write)
      else $error("index port write not taken");

   property p_reg_read;
      @(posedge clk_in) disable iff (rst_in)
      (io_rd_in && dat_hit && index_q == pgp_pkg::REG_BIT_MASK) |=>
         (io_rvalid_out && io_rdata_out == $past(regs_q[8]));
   endproperty
   a_reg_read: assert property (p_reg_read)
      else $error("data port read wrong");

   property p_reserved_zero;
      @(posedge clk_in) disable iff (rst_in)
      (regs_q[0][7:4] == 4'h0) && (regs_q[3][7:5] == 3'h0) &&
      (regs_q[4][7:2] == 6'h0) && (regs_q[5][7] == 1'b0) &&
      (regs_q[5][2] == 1'b0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit set");

   property p_plane_read;
      @(posedge clk_in) disable iff (rst_in)
      (mem_rd_in && !regs_q[5][3] && regs_q[4][1:0] == 2'h2) |=>
         (mem_rdata_out == $past(mem_plane_rdata_in[23:16]));
   endproperty
   a_plane_read: assert property (p_plane_read)
      else $error("plane read selects wrong plane");

   property p_cmp_all_ignored;
      @(posedge clk_in) disable iff (rst_in)
      (mem_rd_in && regs_q[5][3] && regs_q[7][3:0] == 4'h0) |=>
         (mem_rdata_out == 8'hff);
   endproperty
   a_cmp_all_ignored: assert property (p_cmp_all_ignored)
      else $error("compare with no planes must match");

   property p_mask_keeps;
      @(posedge clk_in) disable iff (rst_in)
      (mem_wr_in && regs_q[8] == 8'h00) |=>
         (plane_we_out && plane_wdata_out == $past(latch_q));
   endproperty
   a_mask_keeps: assert property (p_mask_keeps)
      else $error("masked write changed data");

   property p_fill;
      @(posedge clk_in) disable iff (rst_in)
      (mem_wr_in && regs_q[1][0] && regs_q[3][4:3] == 2'h0 &&
       regs_q[8] == 8'hff) |=>
         (plane_wdata_out[7:0] == {8{$past(regs_q[0][0])}});
   endproperty
   a_fill: assert property (p_fill)
      else $error("fill color not applied");

   property p_rotate;
      @(posedge clk_in) disable iff (rst_in)
      (mem_wr_in && regs_q[1][0] == 1'b0 && regs_q[3][4:0] == 5'h01 &&
       regs_q[8] == 8'hff) |=> (plane_wdata_out[7:0] ==
         {$past(mem_wdata_in[0]), $past(mem_wdata_in[7:1])});
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("rotate by one wrong");

   property p_xor;
      @(posedge clk_in) disable iff (rst_in)
      (mem_wr_in && regs_q[1][1] == 1'b0 && regs_q[3][4:0] == 5'h18 &&
       regs_q[8] == 8'hff) |=> (plane_wdata_out[15:8] ==
         ($past(mem_wdata_in) ^ $past(latch_q[15:8])));
   endproperty
   a_xor: assert property (p_xor)
      else $error("xor function wrong");

   property p_idx_read;
      @(posedge clk_in) disable iff (rst_in)
      (io_rd_in && idx_hit) |=> (io_rdata_out == {4'h0, $past(index_q)});
   endproperty
   a_idx_read: assert property (p_idx_read)
      else $error("index port read wrong");

   property p_idx_hold;
      @(posedge clk_in) disable iff (rst_in)
      !(io_wr_in && idx_hit) |=> $stable(index_q);
   endproperty
   a_idx_hold: assert property (p_idx_hold)
      else $error("index changed without index write");

   property p_oob_read;
      @(posedge clk_in) disable iff (rst_in)
      (io_rd_in && dat_hit && index_q > 4'h8) |=> (io_rdata_out == 8'h00);
   endproperty
   a_oob_read: assert property (p_oob_read)
      else $error("unused index read not zero");

   property p_reg_quiet;
      @(posedge clk_in) disable iff (rst_in)
      !io_rd_in |=> (!io_rvalid_out && io_rdata_out == 8'h00);
   endproperty
   a_reg_quiet: assert property (p_reg_quiet)
      else $error("register read data without a read");

   property p_reserved_hi;
      @(posedge clk_in) disable iff (rst_in)
      (regs_q[1][7:4] == 4'h0) && (regs_q[2][7:4] == 4'h0) &&
      (regs_q[6][7:4] == 4'h0) && (regs_q[7][7:4] == 4'h0);
   endproperty
   a_reserved_hi: assert property (p_reserved_hi)
      else $error("reserved high nibble set");

   property p_mem_answer;
      @(posedge clk_in) disable iff (rst_in)
      mem_rd_in |=> mem_rvalid_out;
   endproperty
   a_mem_answer: assert property (p_mem_answer)
      else $error("host read not answered");

   property p_write_strobe;
      @(posedge clk_in) disable iff (rst_in)
      mem_wr_in |=> plane_we_out;
   endproperty
   a_write_strobe: assert property (p_write_strobe)
      else $error("host write not passed to planes");

   property p_mode_copy;
      @(posedge clk_in) disable iff (rst_in)
      1'b1 |=> (write_mode_out == $past(regs_q[5][1:0]) &&
                shift_256_out == $past(regs_q[5][6]));
   endproperty
   a_mode_copy: assert property (p_mode_copy)
      else $error("path mode outputs wrong");

   property p_map_copy;
      @(posedge clk_in) disable iff (rst_in)
      1'b1 |=> (mem_window_out == $past(regs_q[6][3:2]) &&
                gfx_addr_out == $past(regs_q[6][0]));
   endproperty
   a_map_copy: assert property (p_map_copy)
      else $error("memory map outputs wrong");

   property p_cmp_one;
      @(posedge clk_in) disable iff (rst_in)
      (mem_rd_in && regs_q[5][3] && regs_q[7][3:0] == 4'h1) |=>
         (mem_rdata_out == ($past(mem_plane_rdata_in[7:0]) ^
                            {8{!$past(regs_q[2][0])}}));
   endproperty
   a_cmp_one: assert property (p_cmp_one)
      else $error("single plane compare wrong");
endmodule

// [sim/pgp_host_model.sv]
// Host processor model driving register and display-memory accesses
`timescale 1ns/1ps
module pgp_host_model (
   input  wire logic        clk_in,
   output logic             io_wr_out,
   output logic             io_rd_out,
   output logic [15:0]      io_addr_out,
   output logic [7:0]       io_wdata_out,
   output logic             mem_wr_out,
   output logic             mem_rd_out,
   output logic [7:0]       mem_wdata_out,
   output logic [31:0]      planes_out
);
   initial begin
      io_wr_out = 1'b0;
      io_rd_out = 1'b0;
      io_addr_out = 16'h0000;
      io_wdata_out = 8'h00;
      mem_wr_out = 1'b0;
      mem_rd_out = 1'b0;
      mem_wdata_out = 8'h00;
      planes_out = 32'h0000_0000;
   end
   // One register access, held to its taking edge
   task automatic io_acc(input logic wr, input logic [15:0] a,
                         input logic [7:0] d);
      @(posedge clk_in);
      io_wr_out <= wr;
      io_rd_out <= !wr;
      io_addr_out <= a;
      io_wdata_out <= d;
      @(posedge clk_in);
      io_wr_out <= 1'b0;
      io_rd_out <= 1'b0;
      io_addr_out <= ~a;
   endtask
   // One memory access; plane bytes are valid only in the read cycle
   task automatic mem_acc(input logic wr, input logic [7:0] d,
                          input logic [31:0] p);
      @(posedge clk_in);
      mem_wr_out <= wr;
      mem_rd_out <= !wr;
      mem_wdata_out <= d;
      planes_out <= p;
      @(posedge clk_in);
      mem_wr_out <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_wdata_out <= ~d;
      planes_out <= ~p;
   endtask
endmodule

// [sim/planar_graphics_write_read_path_tb.sv]
// Self-checking testbench of the planar graphics path
`timescale 1ns/1ps
module planar_graphics_write_read_path_tb;
   logic        clk;
   logic        rst;
   logic        io_wr, io_rd, io_rvalid, mem_wr, mem_rd, mem_rvalid, we;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata, io_rdata, mem_wdata, mem_rdata;
   logic [31:0] planes, pw;
   logic [8:0]  modes;
   int          miscompares = 0;
   int          cmp_count = 0;
   logic [7:0]  msk [9] = '{pgp_pkg::FILL_COLOR_MASK,
      pgp_pkg::FILL_ENABLE_MASK, pgp_pkg::COMPARE_MASK,
      pgp_pkg::ROTATE_OP_MASK, pgp_pkg::READ_PLANE_MASK,
      pgp_pkg::PATH_MODE_MASK, pgp_pkg::MEM_MAP_MASK,
      pgp_pkg::IGNORE_MASK, pgp_pkg::BIT_MASK_MASK};
   localparam logic [31:0] P = 32'h8c4a_21f3;
   // Directed write rows, one byte per write: rotate/op, fill enable, mask
   localparam logic [31:0] RO = 32'h0b00_1801;
   localparam logic [31:0] FE = 32'h0601_0000;
   localparam logic [31:0] BM = 32'h00ff_ffff;
   logic [31:0] ew;

   always #2 clk = ~clk;

   pgp_host_model i_pgp_host_model (.clk_in(clk), .io_wr_out(io_wr),
      .io_rd_out(io_rd), .io_addr_out(io_addr), .io_wdata_out(io_wdata),
      .mem_wr_out(mem_wr), .mem_rd_out(mem_rd), .mem_wdata_out(mem_wdata),
      .planes_out(planes));

   pgp_top i_pgp_top (.clk_in(clk), .rst_in(rst), .io_wr_in(io_wr),
      .io_rd_in(io_rd), .io_addr_in(io_addr), .io_wdata_in(io_wdata),
      .io_rdata_out(io_rdata), .io_rvalid_out(io_rvalid),
      .mem_wr_in(mem_wr), .mem_rd_in(mem_rd), .mem_wdata_in(mem_wdata),
      .mem_plane_rdata_in(planes), .mem_rdata_out(mem_rdata),
      .mem_rvalid_out(mem_rvalid), .plane_wdata_out(pw),
      .plane_we_out(we), .write_mode_out(modes[8:7]),
      .odd_even_addr_out(modes[6]), .odd_even_shift_out(modes[5]),
      .shift_256_out(modes[4]), .gfx_addr_out(modes[3]),
      .chain_odd_even_out(modes[2]), .mem_window_out(modes[1:0]));

   task automatic finish_test();
      if (miscompares == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bounded wait for a response strobe: 0 register, 1 read, 2 write
   task automatic wait_v(input int k);
      for (int i = 0; i < 8; i++) begin
         #1;
         if ((k == 0 ? io_rvalid : k == 1 ? mem_rvalid : we) === 1'b1) return;
         @(posedge clk);
      end
      chk("response timeout", 0, 1);
      finish_test();
   endtask
   task automatic rd_at(input logic [15:0] a, input logic [7:0] e, string n);
      i_pgp_host_model.io_acc(1'b0, a, 8'h00);
      wait_v(0);
      chk(n, e, io_rdata);
   endtask
   task automatic wr_reg(input logic [3:0] r, input logic [7:0] d);
      i_pgp_host_model.io_acc(1'b1, pgp_pkg::INDEX_PORT_ADDR, {4'h0, r});
      i_pgp_host_model.io_acc(1'b1, pgp_pkg::DATA_PORT_ADDR, d);
   endtask
   task automatic rd_reg(input logic [3:0] r, input logic [7:0] e);
      i_pgp_host_model.io_acc(1'b1, pgp_pkg::INDEX_PORT_ADDR, {4'h0, r});
      rd_at(pgp_pkg::DATA_PORT_ADDR, e, "register");
   endtask
   function automatic logic [31:0] exp_wr(logic [7:0] d, logic [31:0] l,
      logic [2:0] rot, logic [1:0] op, logic [3:0] fc, logic [3:0] fe,
      logic [7:0] bm);
      logic [7:0]  r, s, v, lp;
      logic [31:0] o;
      r = 8'({d, d} >> rot);
      for (int p = 0; p < 4; p++) begin
         lp = l[8*p +: 8];
         s = fe[p] ? {8{fc[p]}} : r;
         case (op)
            2'h0: v = s;
            2'h1: v = s & lp;
            2'h2: v = s | lp;
            default: v = s ^ lp;
         endcase
         o[8*p +: 8] = (v & bm) | (lp & ~bm);
      end
      return o;
   endfunction
   function automatic logic [7:0] exp_cmp(logic [31:0] pl, logic [3:0] cc,
                                          logic [3:0] ign);
      logic [7:0] o;
      o = 8'hff;
      for (int p = 0; p < 4; p++) begin
         if (ign[p]) o &= ~(pl[8*p +: 8] ^ {8{cc[p]}});
      end
      return o;
   endfunction

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int r = 0; r < 9; r++) rd_reg(4'(r), 8'h00);
      for (int r = 0; r < 9; r++) begin
         wr_reg(4'(r), 8'hff);
         rd_reg(4'(r), msk[r]);
      end
      #1 chk("mode outputs", 9'h1ff, modes);
      i_pgp_host_model.io_acc(1'b1, pgp_pkg::INDEX_PORT_ADDR, 8'hf9);
      rd_at(pgp_pkg::INDEX_PORT_ADDR, 8'h09, "index");
      i_pgp_host_model.io_acc(1'b1, pgp_pkg::DATA_PORT_ADDR, 8'h5a);
      rd_at(pgp_pkg::DATA_PORT_ADDR, 8'h00, "index 9");
      rd_at(16'h03cd, 8'h00, "unmapped");
      wr_reg(4'h5, 8'h01);
      wr_reg(4'h6, 8'h09);
      @(posedge clk);
      #1 chk("mode outputs", 9'h08a, modes);
      wr_reg(4'h5, 8'h00);
      for (int p = 0; p < 4; p++) begin
         wr_reg(4'h4, 8'(p));
         i_pgp_host_model.mem_acc(1'b0, 8'h00, P);
         wait_v(1);
         chk("plane read", P[8*p +: 8], mem_rdata);
      end
      wr_reg(4'h5, 8'h08);
      for (int k = 0; k < 5; k++) begin
         wr_reg(4'h2, 8'(4'ha ^ 4'(5 * k)));
         wr_reg(4'h7, 8'(4'hf >> k));
         i_pgp_host_model.mem_acc(1'b0, 8'h00, P);
         wait_v(1);
         chk("compare read", exp_cmp(P, 4'ha ^ 4'(5 * k), 4'hf >> k),
             mem_rdata);
      end
      wr_reg(4'h5, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr_reg(4'h3, {3'h0, 2'(k), 3'(2 * k + 1)});
         wr_reg(4'h0, 8'(4'h5 + 4'(k)));
         wr_reg(4'h1, 8'(4'h9 >> k));
         wr_reg(4'h8, 8'he7 ^ 8'(k));
         i_pgp_host_model.mem_acc(1'b1, 8'h96, 32'h0);
         wait_v(2);
         ew = exp_wr(8'h96, P, 3'(2 * k + 1), 2'(k), 4'h5 + 4'(k),
                     4'h9 >> k, 8'he7 ^ 8'(k));
         chk("plane write", ew, pw);
      end
      wr_reg(4'h0, 8'h05);
      for (int k = 0; k < 4; k++) begin
         wr_reg(4'h3, RO[8*k +: 8]);
         wr_reg(4'h1, FE[8*k +: 8]);
         wr_reg(4'h8, BM[8*k +: 8]);
         i_pgp_host_model.mem_acc(1'b1, 8'h96, 32'h0);
         wait_v(2);
         ew = exp_wr(8'h96, P, RO[8*k +: 3], RO[8*k+3 +: 2], 4'h5,
                     FE[8*k +: 4], BM[8*k +: 8]);
         chk("directed write", ew, pw);
      end
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int r = 0; r < 9; r++) rd_reg(4'(r), 8'h00);
      #1 chk("mode outputs", 9'h000, modes);
      finish_test();
   end
endmodule
